/* logic/imuoq_cfg.svh */
`ifndef IMUOQ_CFG_SVH
`define IMUOQ_CFG_SVH

`define IMUOQ_ADDR_W        7
`define IMUOQ_OFS_BIAS_X_LO 7'h4C
`define IMUOQ_OFS_BIAS_X_HI 7'h4E
`define IMUOQ_OFS_BIAS_Y_LO 7'h50
`define IMUOQ_OFS_BIAS_Y_HI 7'h52
`define IMUOQ_OFS_BIAS_Z_LO 7'h54
`define IMUOQ_OFS_BIAS_Z_HI 7'h56
`define IMUOQ_OFS_QCTL      7'h5A
`define IMUOQ_OFS_FILT      7'h5C
`define IMUOQ_OFS_RANGE     7'h5E
`define IMUOQ_OFS_MISC      7'h60

`define IMUOQ_RST_BIAS      16'h0000
`define IMUOQ_RST_QCTL      16'h0000
`define IMUOQ_RST_FILT      16'h0000
`define IMUOQ_RST_MISC      16'h00C1
`define IMUOQ_RST_TAPS      8'h01
`define IMUOQ_MISC_RD_MASK  16'h1FCF
`define IMUOQ_FILT_RD_MASK  16'h0007

`define IMUOQ_QCTL_WM_HI    15
`define IMUOQ_QCTL_WM_LO    4
`define IMUOQ_QCTL_WATERMARK_POLARITY   3
`define IMUOQ_QCTL_WATERMARK_IRQ_ENABLE    2
`define IMUOQ_QCTL_OVWR     1
`define IMUOQ_QCTL_QMODE    0
`define IMUOQ_FILT_B_HI     2
`define IMUOQ_MISC_BW       12
`define IMUOQ_MISC_OUT_SEL  8
`define IMUOQ_MISC_READY_POLARITY   0
`define IMUOQ_RANGE_LOW     2'h3

`define IMUOQ_DEPTH         512
`define IMUOQ_PTR_W         9
`define IMUOQ_CNT_W         10

`endif

/* logic/imuoq_pkg.sv */
package imuoq_pkg;
	typedef struct packed {
		logic [5:0][31:0] inertial;
		logic [15:0]      temperature;
		logic [15:0]      sample_counter;
		logic [31:0]      sample_timestamp;
	} imuoq_entry_t;

	typedef struct packed {
		logic [2:0][31:0] gyro;
		logic [2:0][31:0] accel;
		logic [2:0][31:0] delta_angle;
		logic [2:0][31:0] delta_velocity;
		logic [15:0]      temperature;
		logic [15:0]      sample_counter;
		logic [31:0]      sample_timestamp;
	} imuoq_raw_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [6:0]  addr;
		logic [15:0] wdata;
	} imuoq_reg_req_t;

	typedef struct packed {
		logic queue_empty;
		logic queue_full;
		logic queue_overrun;
	} imuoq_status_t;
endpackage

/* logic/imuoq_queue.sv */
`timescale 1ns/1ps
`include "imuoq_cfg.svh"

module imuoq_queue
	import imuoq_pkg::*;
(
	input  wire logic                     sys_clk,
	input  wire logic                     srst,
	input  wire logic                     push,
	input  wire logic                     pop,
	input  wire imuoq_entry_t             wr_data,
	output imuoq_entry_t                  rd_data,
	output logic [`IMUOQ_CNT_W-1:0]       count,
	output logic                          empty,
	output logic                          full
);
	imuoq_entry_t                mem [`IMUOQ_DEPTH];
	logic [`IMUOQ_PTR_W-1:0]     wr_ptr_reg;
	logic [`IMUOQ_PTR_W-1:0]     wr_ptr_next;
	logic [`IMUOQ_PTR_W-1:0]     rd_ptr_reg;
	logic [`IMUOQ_PTR_W-1:0]     rd_ptr_next;
	logic [`IMUOQ_CNT_W-1:0]     count_reg;
	logic [`IMUOQ_CNT_W-1:0]     count_next;
	logic                        do_push;
	logic                        do_pop;

	assign empty   = (count_reg == '0);
	assign full    = (count_reg == `IMUOQ_CNT_W'(`IMUOQ_DEPTH));
	assign count   = count_reg;
	assign rd_data = mem[rd_ptr_reg];

	always_comb begin
		// Full push only goes in when the oldest leaves the same cycle
		do_push     = push && (!full || pop);
		do_pop      = pop && !empty;
		wr_ptr_next = do_push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
		rd_ptr_next = do_pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
		count_next  = count_reg;
		if (do_push && !do_pop) begin
			count_next = count_reg + 1'b1;
		end else if (do_pop && !do_push) begin
			count_next = count_reg - 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg  <= count_next;
		end
	end

	// Storage has no reset; contents are only read behind count
	always_ff @(posedge sys_clk) begin
		if (do_push) begin
			mem[wr_ptr_reg] <= wr_data;
		end
	end
endmodule

/* logic/imuoq_top.sv */
// Behaviour
// - Two bias words form each accel correction
// - Bias from host writes or estimate update
// - Watermark count in bits 15:4
// - Watermark compares queued count to threshold
// - Bit 3 picks watermark pin level
// - Bit 2 enables pin, else released
// - Direct mode loads outputs, pulses ready
// - Queued mode pushes samples, toggles ready
// - Status word read pops oldest sample in queued mode
// - Entry holds six channels plus extras
// - Status flags hold in direct mode, except that a status read clears overrun
// - Filter bits 2:0 give log2 of taps per stage
// - Range identifier reports gyro range code
// - Misc bit 12 selects sensor bandwidth
// - Output select picks readings or deltas
// - Ready polarity sets stable data level
`timescale 1ns/1ps
`include "imuoq_cfg.svh"

module imuoq_top
	import imuoq_pkg::*;
#(
	parameter logic [1:0] GYRO_RANGE_CODE = 2'h3
)
(
	input  wire logic                 sys_clk,
	input  wire logic                 srst,
	input  wire imuoq_reg_req_t       reg_req,
	output logic [15:0]               reg_rdata,
	output logic                      reg_rvalid,
	input  wire logic                 sample_valid,
	input  wire imuoq_raw_t           sample_in,
	input  wire logic                 bias_update_cmd,
	input  wire logic [2:0][31:0]     accel_bias_estimate,
	input  wire logic                 diag_status_read,
	output imuoq_entry_t              output_sample,
	output logic                      data_ready_pin,
	output logic                      watermark_pin,
	output logic                      watermark_pin_oe_n,
	output logic [`IMUOQ_CNT_W-1:0]   queue_fill_count,
	output imuoq_status_t             queue_status,
	output logic [2:0]                filter_taps_log2,
	output logic [7:0]                filter_taps,
	output logic                      sensor_bandwidth_select
);
	logic [5:0][15:0]           bias_reg;
	logic [5:0][15:0]           bias_next;
	logic [15:0]                qctl_reg;
	logic [15:0]                qctl_next;
	logic [15:0]                filt_reg;
	logic [15:0]                filt_next;
	logic [15:0]                misc_reg;
	logic [15:0]                misc_next;
	logic [7:0]                 taps_reg;
	logic [7:0]                 taps_next;
	logic [15:0]                rdata_reg;
	logic [15:0]                rdata_next;
	logic                       rvalid_reg;
	logic                       rvalid_next;
	imuoq_entry_t               out_reg;
	imuoq_entry_t               out_next;
	logic                       dr_reg;
	logic                       dr_next;
	logic                       overrun_reg;
	logic                       overrun_next;
	imuoq_entry_t               fresh;
	imuoq_entry_t               head;
	logic [`IMUOQ_CNT_W-1:0]    q_count;
	logic                       q_empty;
	logic                       q_full;
	logic                       queue_mode;
	logic                       overwrite;
	logic                       out_sel;
	logic [11:0]                wm_level;
	logic                       wm_active;
	logic                       q_push;
	logic                       q_pop;
	logic                       host_pop;
	logic                       discard;
	logic                       dropped;

	function automatic logic [2:0] bias_index(input logic [6:0] addr);
		logic [6:0] rel;
		rel = addr - `IMUOQ_OFS_BIAS_X_LO;
		return rel[3:1];
	endfunction

	function automatic logic is_bias(input logic [6:0] addr);
		return addr >= `IMUOQ_OFS_BIAS_X_LO
			&& addr <= `IMUOQ_OFS_BIAS_Z_HI
			&& !addr[0];
	endfunction

	function automatic logic [31:0] bias_word(
		input logic [5:0][15:0] b,
		input int               axis
	);
		return {b[2*axis+1], b[2*axis]};
	endfunction

	// Polarity bit 1 shows the active state as a high level
	function automatic logic pin_level(
		input logic pol,
		input logic active
	);
		return pol ? active : !active;
	endfunction

	assign queue_mode = qctl_reg[`IMUOQ_QCTL_QMODE];
	assign overwrite  = qctl_reg[`IMUOQ_QCTL_OVWR];
	assign wm_level   = qctl_reg[`IMUOQ_QCTL_WM_HI:`IMUOQ_QCTL_WM_LO];
	assign out_sel    = misc_reg[`IMUOQ_MISC_OUT_SEL];

	// Sample content chosen once so direct output and queue see the same data
	always_comb begin
		fresh = '0;
		for (int i = 0; i < 3; i++) begin
			if (out_sel) begin
				fresh.inertial[i]   = sample_in.delta_angle[i];
				fresh.inertial[i+3] = sample_in.delta_velocity[i];
			end else begin
				fresh.inertial[i]   = sample_in.gyro[i];
				fresh.inertial[i+3] = sample_in.accel[i]
					+ bias_word(bias_reg, i);
			end
		end
		fresh.temperature      = sample_in.temperature;
		fresh.sample_counter   = sample_in.sample_counter;
		fresh.sample_timestamp = sample_in.sample_timestamp;
	end

	imuoq_queue u_queue (
		.sys_clk (sys_clk),
		.srst    (srst),
		.push    (q_push),
		.pop     (q_pop),
		.wr_data (fresh),
		.rd_data (head),
		.count   (q_count),
		.empty   (q_empty),
		.full    (q_full)
	);

	always_comb begin
		host_pop = queue_mode && diag_status_read && !q_empty;
		// Overwrite mode frees a slot by discarding the oldest entry
		discard  = queue_mode && sample_valid && q_full && overwrite
			&& !host_pop;
		dropped  = queue_mode && sample_valid && q_full && !overwrite;
		q_push   = queue_mode && sample_valid && !dropped;
		q_pop    = host_pop || discard;
	end

	// Register group
	always_comb begin
		bias_next   = bias_reg;
		qctl_next   = qctl_reg;
		filt_next   = filt_reg;
		misc_next   = misc_reg;
		rdata_next  = rdata_reg;
		rvalid_next = reg_req.rd;
		if (reg_req.wr) begin
			if (is_bias(reg_req.addr)) begin
				bias_next[bias_index(reg_req.addr)] = reg_req.wdata;
			end
			unique case (reg_req.addr)
				`IMUOQ_OFS_QCTL: qctl_next = reg_req.wdata;
				`IMUOQ_OFS_FILT: filt_next = reg_req.wdata;
				`IMUOQ_OFS_MISC: misc_next = reg_req.wdata;
				default: ;
			endcase
		end
		// Estimate load beats a host write in the same cycle
		if (bias_update_cmd) begin
			for (int i = 0; i < 3; i++) begin
				bias_next[2*i]   = accel_bias_estimate[i][15:0];
				bias_next[2*i+1] = accel_bias_estimate[i][31:16];
			end
		end
		if (reg_req.rd) begin
			rdata_next = 16'h0000;
			if (is_bias(reg_req.addr)) begin
				rdata_next = bias_reg[bias_index(reg_req.addr)];
			end
			unique case (reg_req.addr)
				`IMUOQ_OFS_QCTL: rdata_next = qctl_reg;
				`IMUOQ_OFS_FILT: rdata_next = filt_reg
					& `IMUOQ_FILT_RD_MASK;
				`IMUOQ_OFS_RANGE: rdata_next = {12'h000, GYRO_RANGE_CODE,
					`IMUOQ_RANGE_LOW};
				`IMUOQ_OFS_MISC: rdata_next = misc_reg
					& `IMUOQ_MISC_RD_MASK;
				default: ;
			endcase
		end
		// Tap count kept in a flop so the output carries no shifter
		taps_next = 8'h01 << filt_next[`IMUOQ_FILT_B_HI:0];
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			for (int i = 0; i < 6; i++) begin
				bias_reg[i] <= `IMUOQ_RST_BIAS;
			end
			qctl_reg   <= `IMUOQ_RST_QCTL;
			filt_reg   <= `IMUOQ_RST_FILT;
			misc_reg   <= `IMUOQ_RST_MISC;
			taps_reg   <= `IMUOQ_RST_TAPS;
			rdata_reg  <= 16'h0000;
			rvalid_reg <= 1'b0;
		end else begin
			bias_reg   <= bias_next;
			qctl_reg   <= qctl_next;
			filt_reg   <= filt_next;
			misc_reg   <= misc_next;
			taps_reg   <= taps_next;
			rdata_reg  <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// Output and ready group
	always_comb begin
		out_next     = out_reg;
		dr_next      = 1'b0;
		overrun_next = overrun_reg;
		if (!queue_mode) begin
			if (sample_valid) begin
				out_next = fresh;
			end
			dr_next = sample_valid;
		end else begin
			if (host_pop) begin
				out_next = head;
			end
			dr_next = dr_reg ^ q_push;
		end
		// Status read clears, a loss in the same cycle still sets
		if (diag_status_read) begin
			overrun_next = 1'b0;
		end
		if (dropped || discard) begin
			overrun_next = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			out_reg     <= '0;
			dr_reg      <= 1'b0;
			overrun_reg <= 1'b0;
		end else begin
			out_reg     <= out_next;
			dr_reg      <= dr_next;
			overrun_reg <= overrun_next;
		end
	end

	// Zero threshold still needs one sample, hence strict compare
	assign wm_active = {2'b00, q_count} > wm_level;

	always_comb begin
		watermark_pin = pin_level(qctl_reg[`IMUOQ_QCTL_WATERMARK_POLARITY],
			wm_active);
		// Released pin protects a host that shares the line
		watermark_pin_oe_n = !qctl_reg[`IMUOQ_QCTL_WATERMARK_IRQ_ENABLE];
		data_ready_pin = pin_level(misc_reg[`IMUOQ_MISC_READY_POLARITY],
			dr_reg);
	end

	assign output_sample           = out_reg;
	assign reg_rdata               = rdata_reg;
	assign reg_rvalid              = rvalid_reg;
	assign queue_fill_count        = q_count;
	assign queue_status            = '{queue_empty:   q_empty,
		queue_full:    q_full,
		queue_overrun: overrun_reg};
	assign filter_taps_log2        = filt_reg[`IMUOQ_FILT_B_HI:0];
	assign filter_taps             = taps_reg;
	assign sensor_bandwidth_select = misc_reg[`IMUOQ_MISC_BW];
endmodule

/* bench/imuoq_host.sv */
`timescale 1ns/1ps
module imuoq_host
	import imuoq_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_rvalid,
	output imuoq_reg_req_t   reg_req,
	output logic             diag_status_read
);
	initial begin
		reg_req = '0;
		diag_status_read = 0;
	end
	// Strobes are one-cycle pulses; holding them would repeat the access
	task automatic acc(input logic w, input logic [6:0] a,
		input logic [15:0] d, output logic [15:0] q);
		@(negedge sys_clk);
		reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge sys_clk);
		reg_req = '0;
		q = reg_rvalid ? reg_rdata : 16'hXXXX;
	endtask
	// Status word read may come at any time, even with nothing queued
	task automatic pop();
		@(negedge sys_clk);
		diag_status_read = 1;
		@(negedge sys_clk);
		diag_status_read = 0;
	endtask
endmodule

/* bench/imuoq_monitor.sv */
`timescale 1ns/1ps
`include "imuoq_cfg.svh"
module imuoq_monitor
	import imuoq_pkg::*;
(
	input wire logic                    sys_clk,
	input wire logic                    srst,
	input wire imuoq_reg_req_t          reg_req,
	input wire logic                    sample_valid,
	input wire logic                    diag_status_read,
	input wire imuoq_entry_t            output_sample,
	input wire logic                    data_ready_pin,
	input wire logic                    watermark_pin,
	input wire logic                    watermark_pin_oe_n,
	input wire logic [`IMUOQ_CNT_W-1:0] queue_fill_count,
	input wire imuoq_status_t           queue_status,
	input wire logic [2:0]              filter_taps_log2,
	input wire logic [7:0]              filter_taps,
	input wire logic                    sensor_bandwidth_select
);
	// Shadows of the control words, rebuilt from bus writes
	logic [15:0] qc_reg, qc_next, ms_reg, ms_next;
	logic [15:0] fl_reg, fl_next;
	logic        q, full, empty;
	always_comb begin
		qc_next = qc_reg;
		ms_next = ms_reg;
		fl_next = fl_reg;
		if (reg_req.wr && reg_req.addr == `IMUOQ_OFS_FILT)
			fl_next = reg_req.wdata;
		if (reg_req.wr && reg_req.addr == `IMUOQ_OFS_QCTL)
			qc_next = reg_req.wdata;
		if (reg_req.wr && reg_req.addr == `IMUOQ_OFS_MISC)
			ms_next = reg_req.wdata;
	end
	always_ff @(posedge sys_clk) begin
		qc_reg <= srst ? 16'h0000 : qc_next;
		ms_reg <= srst ? 16'h00C1 : ms_next;
		fl_reg <= srst ? 16'h0000 : fl_next;
	end
	assign q = qc_reg[0];
	assign full = queue_status.queue_full;
	assign empty = queue_status.queue_empty;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);
	taps_pow_a: assert property (filter_taps_log2 == fl_reg[2:0] &&
		filter_taps == 8'h01 << fl_reg[2:0])
		else $error("taps not two to the power of setting");
	wm_drive_a: assert property (watermark_pin_oe_n == !qc_reg[2])
		else $error("watermark drive enable wrong");
	wm_level_a: assert property (qc_reg[2] |->
		watermark_pin ==
		((queue_fill_count > qc_reg[15:4]) ~^ qc_reg[3]))
		else $error("watermark level wrong");
	bw_sel_a: assert property (sensor_bandwidth_select == ms_reg[12])
		else $error("bandwidth select wrong");
	direct_rdy_a: assert property (
		!q && sample_valid ##1 !sample_valid |->
		data_ready_pin == ms_reg[0] ##1 data_ready_pin != ms_reg[0])
		else $error("direct ready pulse wrong");
	q_toggle_a: assert property (q && sample_valid && !full |=>
		data_ready_pin != $past(data_ready_pin))
		else $error("ready did not toggle on enqueue");
	q_count_a: assert property (
		q && sample_valid && !full && !diag_status_read
		|=> queue_fill_count == $past(queue_fill_count) + 1)
		else $error("enqueue count wrong");
	pop_count_a: assert property (q && diag_status_read && !empty &&
		!sample_valid |=> queue_fill_count == $past(queue_fill_count) - 1)
		else $error("pop count wrong");
	empty_pop_a: assert property (diag_status_read && empty && !sample_valid
		|=> $stable(output_sample) && queue_fill_count == 0)
		else $error("pop on empty changed state");
	stop_full_a: assert property (q && !qc_reg[1] && full && sample_valid &&
		!diag_status_read |=> queue_status.queue_overrun &&
		queue_fill_count == `IMUOQ_DEPTH && $stable(output_sample))
		else $error("full queue took sample");
	flags_a: assert property (full == (queue_fill_count == `IMUOQ_DEPTH) &&
		empty == (queue_fill_count == 0))
		else $error("status flags disagree with count");
	direct_c: cover property (!q && sample_valid);
	pop_c: cover property (q && diag_status_read && !empty);
	drop_c: cover property (q && full && sample_valid && !qc_reg[1]);
endmodule
bind imuoq_top imuoq_monitor mon_u (.*);

/* bench/imu_output_queue_and_config_tb.sv */
`timescale 1ns/1ps
`include "imuoq_cfg.svh"
module imu_output_queue_and_config_tb
	import imuoq_pkg::*;
;
	logic                    sys_clk = 0, srst = 1;
	logic                    sample_valid = 0, bias_update_cmd = 0;
	imuoq_raw_t              sample_in = '0;
	logic [2:0][31:0]        accel_bias_estimate = '0;
	imuoq_reg_req_t          reg_req;
	imuoq_entry_t            output_sample, ev = '0, mq[$];
	imuoq_status_t           queue_status;
	logic [15:0]             reg_rdata, q, qc = '0, ms = 16'h00C1, w[11];
	logic                    reg_rvalid, data_ready_pin, watermark_pin;
	logic                    watermark_pin_oe_n, diag_status_read;
	logic                    sensor_bandwidth_select;
	logic [`IMUOQ_CNT_W-1:0] queue_fill_count;
	logic [2:0]              filter_taps_log2;
	logic [7:0]              filter_taps;
	logic [31:0]             bias[3] = '{default: '0};
	logic [31:0]             lfsr = 32'hE52464FA;
	int                      bad_count = 0, n_compared = 0, i;
	// Last entry is an unmapped address
	logic [6:0]  ad[11] = '{7'h4C, 7'h4E, 7'h50, 7'h52, 7'h54, 7'h56,
		7'h5A, 7'h5C, 7'h5E, 7'h60, 7'h70};
	// Reset values, and the bits that a write can change
	logic [15:0] rv[11] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0007, 16'h00C1,
		16'h0000};
	logic [15:0] mk[11] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
		16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0007, 16'h0000, 16'h1FCF,
		16'h0000};

	imuoq_top #(.GYRO_RANGE_CODE(2'h1)) dut_u (.*);
	imuoq_host host_u (.*);

	always #12.5 sys_clk = ~sys_clk;

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction

	function automatic imuoq_entry_t ex(input imuoq_raw_t r);
		imuoq_entry_t e;
		for (int k = 0; k < 3; k++) begin
			e.inertial[k] = ms[8] ? r.delta_angle[k] : r.gyro[k];
			e.inertial[k+3] = ms[8] ? r.delta_velocity[k] :
				r.accel[k] + bias[k];
		end
		e.temperature = r.temperature;
		e.sample_counter = r.sample_counter;
		e.sample_timestamp = r.sample_timestamp;
		return e;
	endfunction

	task automatic cmp_v(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic cmp_e(input imuoq_entry_t e);
		n_compared++;
		if (output_sample !== e) begin
			bad_count++;
			$display("wrong value at %0t: output sample", $time);
		end
	endtask

	task automatic cfg(input logic [6:0] a, input logic [15:0] d);
		host_u.acc(1, a, d, q);
		if (a == `IMUOQ_OFS_QCTL)
			qc = d;
		if (a == `IMUOQ_OFS_MISC)
			ms = d;
	endtask

	task automatic chk();
		cmp_e(ev);
		cmp_v(queue_fill_count, 16'(mq.size()));
		if (qc[2])
			cmp_v(watermark_pin, {(mq.size() > qc[15:4]) ~^ qc[3]});
	endtask

	task automatic samp();
		imuoq_raw_t r;
		for (int k = 0; k < 14; k++)
			r[k*32+:32] = rnd();
		@(negedge sys_clk);
		sample_valid = 1;
		sample_in = r;
		@(negedge sys_clk);
		sample_valid = 0;
		if (!qc[0]) begin
			ev = ex(r);
			cmp_v(data_ready_pin, ms[0]);
		end else if (mq.size() < 512 || qc[1]) begin
			// Overwrite drops the oldest entry first
			if (mq.size() == 512)
				void'(mq.pop_front());
			mq.push_back(ex(r));
		end
		chk();
	endtask

	task automatic pop();
		host_u.pop();
		if (qc[0] && mq.size() > 0)
			ev = mq.pop_front();
		chk();
	endtask

	task automatic results();
		if (bad_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (2) @(negedge sys_clk);
		srst = 0;
		for (i = 0; i < 11; i++) begin
			host_u.acc(0, ad[i], 16'h0000, q);
			cmp_v(q, rv[i]);
		end
		for (i = 0; i < 11; i++) begin
			w[i] = 16'(rnd());
			host_u.acc(1, ad[i], w[i], q);
		end
		for (i = 0; i < 11; i++) begin
			host_u.acc(0, ad[i], 16'h0000, q);
			cmp_v(q, w[i] & mk[i] | rv[i] & ~mk[i]);
		end
		for (i = 0; i < 3; i++)
			bias[i] = {w[2*i+1], w[2*i]};
		cmp_v(filter_taps, 16'h0001 << w[7][2:0]);
		cmp_v(filter_taps_log2, w[7][2:0]);
		cfg(`IMUOQ_OFS_QCTL, 16'h0000);
		cfg(`IMUOQ_OFS_MISC, 16'h00C1);
		repeat (2) samp();
		@(negedge sys_clk);
		accel_bias_estimate = {rnd(), rnd(), rnd()};
		bias_update_cmd = 1;
		@(negedge sys_clk);
		bias_update_cmd = 0;
		for (i = 0; i < 3; i++)
			bias[i] = accel_bias_estimate[i];
		for (i = 0; i < 6; i++) begin
			host_u.acc(0, ad[i], 16'h0000, q);
			cmp_v(q, bias[i/2][16*(i%2)+:16]);
		end
		samp();
		cfg(`IMUOQ_OFS_MISC, 16'h1100);
		cmp_v(sensor_bandwidth_select, 16'h0001);
		samp();
		cfg(`IMUOQ_OFS_MISC, 16'h00C1);
		cfg(`IMUOQ_OFS_QCTL, 16'h002D);
		repeat (4) samp();
		repeat (5) pop();
		cfg(`IMUOQ_OFS_QCTL, 16'h0005);
		repeat (514) samp();
		cmp_v(queue_status.queue_overrun, 16'h0001);
		cfg(`IMUOQ_OFS_QCTL, 16'h0007);
		repeat (3) samp();
		repeat (2) pop();
		cfg(`IMUOQ_OFS_QCTL, 16'h0000);
		cmp_v(watermark_pin_oe_n, 16'h0001);
		// Queue contents stay put while in direct mode
		samp();
		pop();
		cmp_v(queue_status, 16'h0000);
		results();
	end
endmodule
